//--- hw/ptc_top.sv
// periodic tick counter: AXI4-Lite registers, tick count, interrupt
// assumes the three source clocks are slow signals sampled here and
// a debug level that is high while the system is halted
//
// The implementer's own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module ptc_top (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // clock sources and debug halt
  input  wire logic        low_power_osc_clock_in,
  input  wire logic        external_ref_clock_in,
  input  wire logic        internal_ref_clock_in,
  input  wire logic        debug_halt_in,
  // write address channel
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [7:0]  s_axi_awaddr_in,
  input  wire logic [2:0]  s_axi_awprot_in,
  // write data channel
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  // write response channel
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  output logic [1:0]       s_axi_bresp_out,
  // read address channel
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  input  wire logic [7:0]  s_axi_araddr_in,
  input  wire logic [2:0]  s_axi_arprot_in,
  // read data channel
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  // interrupt
  output logic             irq_out
);

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  logic [7:0]  tick_compare_value_reg;
  logic [7:0]  tick_count_reg;
  logic [1:0]  source_select_reg;
  logic [3:0]  divider_select_reg;
  logic        periodic_irq_enable_reg;
  logic        periodic_flag_reg;
  logic        periodic_flag_next;

  // ---------------------------------------------------------------
  // write channel holding state
  // ---------------------------------------------------------------
  logic        aw_full_reg;
  logic        aw_full_next;
  logic        w_full_reg;
  logic        w_full_next;
  logic [7:0]  aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        aw_take;
  logic        w_take;
  logic        do_write;
  logic        wr_lane0;
  ptc_pkg::ptc_sel_t wr_sel;
  ptc_pkg::ptc_sel_t rd_sel;
  logic        ar_take;

  // ---------------------------------------------------------------
  // write side effects
  // ---------------------------------------------------------------
  logic        wr_ctrl;
  logic        wr_compare;
  logic        wr_status;
  logic        wr_mask;
  logic [1:0]  new_src;
  logic [3:0]  new_div;
  logic        flag_clear;
  logic        counters_clear;

  // ---------------------------------------------------------------
  // counting path
  // ---------------------------------------------------------------
  logic [2:0]  src_rise;
  logic        sel_rise;
  logic        ps_tick;
  logic        ps_on;
  logic        running;
  logic        wrap_event;
  logic [17:0] ratio;

  // ---------------------------------------------------------------
  // bus handshakes
  // ---------------------------------------------------------------
  assign aw_take  = s_axi_awvalid_in & s_axi_awready_out;
  assign w_take   = s_axi_wvalid_in & s_axi_wready_out;
  assign ar_take  = s_axi_arvalid_in & s_axi_arready_out;
  // a write completes once both halves are held and no reply waits
  assign do_write = aw_full_reg & w_full_reg & ~s_axi_bvalid_out;
  assign aw_full_next = (aw_full_reg | aw_take) & ~do_write;
  assign w_full_next  = (w_full_reg | w_take) & ~do_write;
  assign wr_sel   = ptc_pkg::ptc_decode(aw_addr_reg);
  assign rd_sel   = ptc_pkg::ptc_decode(s_axi_araddr_in);
  // all registers are one byte wide, only lane 0 carries them
  assign wr_lane0 = do_write & w_strb_reg[0];

  // address and data are taken in either order, then held
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      aw_full_reg       <= 1'b0;
      w_full_reg        <= 1'b0;
      s_axi_awready_out <= 1'b0;
      s_axi_wready_out  <= 1'b0;
    end else begin
      aw_full_reg       <= aw_full_next;
      w_full_reg        <= w_full_next;
      s_axi_awready_out <= ~aw_full_next;
      s_axi_wready_out  <= ~w_full_next;
    end
  end

  // captured payloads, no reset needed beyond a defined value
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      aw_addr_reg <= 8'h00;
      w_data_reg  <= 32'h00000000;
      w_strb_reg  <= 4'h0;
    end else begin
      if (aw_take) begin
        aw_addr_reg <= s_axi_awaddr_in;
      end
      if (w_take) begin
        w_data_reg <= s_axi_wdata_in;
        w_strb_reg <= s_axi_wstrb_in;
      end
    end
  end

  // write response, error for an unmapped address
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out  <= ptc_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid_out <= 1'b1;
      s_axi_bresp_out  <= (wr_sel == ptc_pkg::PTC_SEL_NONE) ?
                          ptc_pkg::RESP_SLVERR : ptc_pkg::RESP_OKAY;
    end else if (s_axi_bready_in) begin
      s_axi_bvalid_out <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // decoded write strobes and clear conditions
  // ---------------------------------------------------------------
  assign wr_ctrl    = wr_lane0 & (wr_sel == ptc_pkg::PTC_SEL_CTRL);
  assign wr_compare = wr_lane0 & (wr_sel == ptc_pkg::PTC_SEL_COMPARE);
  assign wr_status  = wr_lane0 & (wr_sel == ptc_pkg::PTC_SEL_STATUS);
  assign wr_mask    = wr_lane0 & (wr_sel == ptc_pkg::PTC_SEL_MASK);
  assign new_src    = w_data_reg[ptc_pkg::SRC_HI:ptc_pkg::SRC_LO];
  assign new_div    = w_data_reg[ptc_pkg::DIV_HI:ptc_pkg::DIV_LO];
  // one written to the flag, through either alias
  assign flag_clear = (wr_ctrl & w_data_reg[ptc_pkg::FLAG_BIT]) |
                      (wr_status & w_data_reg[ptc_pkg::EVT_BIT]);
  // rewriting the same source or divider keeps the counts running
  assign counters_clear = wr_compare
                        | (wr_ctrl & (new_src != source_select_reg))
                        | (wr_ctrl & (new_div != divider_select_reg));

  // configuration fields of the control register
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      source_select_reg  <= ptc_pkg::SRC_LPO;
      divider_select_reg <= ptc_pkg::DIV_OFF;
    end else if (wr_ctrl) begin
      source_select_reg  <= new_src;
      divider_select_reg <= new_div;
    end
  end

  // interrupt enable, reachable from control and mask registers
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      periodic_irq_enable_reg <= 1'b0;
    end else if (wr_ctrl) begin
      periodic_irq_enable_reg <= w_data_reg[ptc_pkg::IEN_BIT];
    end else if (wr_mask) begin
      periodic_irq_enable_reg <= w_data_reg[ptc_pkg::EVT_BIT];
    end
  end

  // compare value, taken from byte lane 0 of the data
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      tick_compare_value_reg <= ptc_pkg::COMPARE_RST;
    end else if (wr_compare) begin
      tick_compare_value_reg <= w_data_reg[7:0];
    end
  end

  // ---------------------------------------------------------------
  // source selection and prescaler
  // ---------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < ptc_pkg::NUM_SRC; gi = gi + 1) begin : g_src
      logic src_level;
      if (gi == 0) begin : g_lpo
        assign src_level = low_power_osc_clock_in;
      end else if (gi == 1) begin : g_ext
        assign src_level = external_ref_clock_in;
      end else begin : g_int
        assign src_level = internal_ref_clock_in;
      end
      ptc_src_edge u_edge (
        .clk_in   (clk_in),
        .rst_n_in (rst_n_in),
        .src_in   (src_level),
        .rise_out (src_rise[gi])
      );
    end
  endgenerate

  // source code 00 oscillator, 01 external, 1x internal
  always_comb begin
    if (source_select_reg[1]) begin
      sel_rise = src_rise[2];
    end else if (source_select_reg == ptc_pkg::SRC_EXT) begin
      sel_rise = src_rise[1];
    end else begin
      sel_rise = src_rise[0];
    end
  end

  // ratio from divider code and source bit 0
  assign ratio   = ptc_pkg::ptc_ratio(divider_select_reg,
                                      source_select_reg[0]);
  assign ps_on   = (divider_select_reg != ptc_pkg::DIV_OFF);
  // a halted system stops prescaler and tick counting but keeps the counts
  assign running = ps_on & ~debug_halt_in;

  ptc_prescaler u_prescaler (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .clear_in (counters_clear | ~ps_on),
    .run_in   (running),
    .edge_in  (sel_rise),
    .ratio_in (ratio),
    .tick_out (ps_tick)
  );

  // ---------------------------------------------------------------
  // tick count and wrap
  // ---------------------------------------------------------------
  // the match is seen on the tick that moves count to zero,
  // so a compare of zero wraps on every tick
  assign wrap_event = ps_tick & running &
                      (tick_count_reg == tick_compare_value_reg);

  always_ff @(posedge clk_in) begin
    if (!rst_n_in || counters_clear || !ps_on) begin
      tick_count_reg <= ptc_pkg::COUNT_RST;
    end else if (wrap_event) begin
      tick_count_reg <= ptc_pkg::COUNT_RST;
    end else if (ps_tick && running) begin
      tick_count_reg <= tick_count_reg + 8'h01;
    end
  end

  // ---------------------------------------------------------------
  // periodic flag and interrupt
  // ---------------------------------------------------------------
  // a wrap in the same cycle as a clear leaves the flag set
  always_comb begin
    periodic_flag_next = periodic_flag_reg;
    if (flag_clear) begin
      periodic_flag_next = 1'b0;
    end
    if (wrap_event) begin
      periodic_flag_next = 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      periodic_flag_reg <= 1'b0;
      irq_out           <= 1'b0;
    end else begin
      periodic_flag_reg <= periodic_flag_next;
      // registered from the next flag value, so the request rises on the same edge as the flag
      irq_out <= periodic_flag_next & periodic_irq_enable_reg;
    end
  end

  // ---------------------------------------------------------------
  // read channel
  // ---------------------------------------------------------------
  // count has no write path, so reading it is the only access
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out  <= 1'b0;
      s_axi_rdata_out   <= 32'h00000000;
      s_axi_rresp_out   <= ptc_pkg::RESP_OKAY;
    end else if (ar_take) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out  <= 1'b1;
      s_axi_rresp_out   <= ptc_pkg::RESP_OKAY;
      s_axi_rdata_out   <= 32'h00000000;
      unique case (rd_sel)
        ptc_pkg::PTC_SEL_CTRL: begin
          s_axi_rdata_out[7:0] <= {periodic_flag_reg,
                                   source_select_reg,
                                   periodic_irq_enable_reg,
                                   divider_select_reg};
        end
        ptc_pkg::PTC_SEL_COUNT: begin
          s_axi_rdata_out[7:0] <= tick_count_reg;
        end
        ptc_pkg::PTC_SEL_COMPARE: begin
          s_axi_rdata_out[7:0] <= tick_compare_value_reg;
        end
        ptc_pkg::PTC_SEL_STATUS: begin
          s_axi_rdata_out[ptc_pkg::EVT_BIT] <= periodic_flag_reg;
        end
        ptc_pkg::PTC_SEL_MASK: begin
          s_axi_rdata_out[ptc_pkg::EVT_BIT] <= periodic_irq_enable_reg;
        end
        ptc_pkg::PTC_SEL_NONE: begin
          s_axi_rresp_out <= ptc_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid_out) begin
      if (s_axi_rready_in) begin
        s_axi_rvalid_out  <= 1'b0;
        s_axi_arready_out <= 1'b1;
      end
    end else begin
      s_axi_arready_out <= 1'b1;
    end
  end

endmodule
`default_nettype wire

//--- hw/ptc_pkg.sv
// periodic tick counter: constants, register map and divide table
// assumes a single 40 MHz register clock and an AXI4-Lite master

package ptc_pkg;

  // ---------------------------------------------------------------
  // bus and register map
  // ---------------------------------------------------------------
  localparam int          ADDR_W       = 8;
  localparam int          DATA_W       = 32;
  localparam logic [7:0]  OFS_CTRL     = 8'h00;
  localparam logic [7:0]  OFS_COUNT    = 8'h04;
  localparam logic [7:0]  OFS_COMPARE  = 8'h08;
  localparam logic [7:0]  OFS_STATUS   = 8'h0C;
  localparam logic [7:0]  OFS_MASK     = 8'h10;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  // ---------------------------------------------------------------
  // field layout of tick_status_control
  // ---------------------------------------------------------------
  localparam int          FLAG_BIT     = 7;
  localparam int          SRC_HI       = 6;
  localparam int          SRC_LO       = 5;
  localparam int          IEN_BIT      = 4;
  localparam int          DIV_HI       = 3;
  localparam int          DIV_LO       = 0;
  localparam int          EVT_BIT      = 0;
  localparam int          NUM_SRC      = 3;
  localparam int          RATIO_W      = 18;

  // ---------------------------------------------------------------
  // reset values and codes
  // ---------------------------------------------------------------
  localparam logic [7:0]  COMPARE_RST  = 8'h00;
  localparam logic [7:0]  COUNT_RST    = 8'h00;
  localparam logic [1:0]  SRC_LPO      = 2'h0;
  localparam logic [1:0]  SRC_EXT      = 2'h1;
  localparam logic [3:0]  DIV_OFF      = 4'h0;

  // ---------------------------------------------------------------
  // one-hot register select, shared by read and write paths
  // ---------------------------------------------------------------
  typedef enum logic [5:0] {
    PTC_SEL_CTRL    = 6'h01,
    PTC_SEL_COUNT   = 6'h02,
    PTC_SEL_COMPARE = 6'h04,
    PTC_SEL_STATUS  = 6'h08,
    PTC_SEL_MASK    = 6'h10,
    PTC_SEL_NONE    = 6'h20
  } ptc_sel_t;

  function automatic ptc_sel_t ptc_decode(input logic [7:0] addr);
    unique case (addr)
      OFS_CTRL:    return PTC_SEL_CTRL;
      OFS_COUNT:   return PTC_SEL_COUNT;
      OFS_COMPARE: return PTC_SEL_COMPARE;
      OFS_STATUS:  return PTC_SEL_STATUS;
      OFS_MASK:    return PTC_SEL_MASK;
      default:     return PTC_SEL_NONE;
    endcase
  endfunction

  // divide ratio from divider code and source bit 0, zero when off
  function automatic logic [17:0] ptc_ratio(input logic [3:0] div,
                                            input logic       sel0);
    logic [17:0] r;
    r = 18'h00000;
    if (!sel0) begin
      unique case (div)
        4'h1: r = 18'h00008;  4'h2: r = 18'h00020;
        4'h3: r = 18'h00040;  4'h4: r = 18'h00080;
        4'h5: r = 18'h00100;  4'h6: r = 18'h00200;
        4'h7: r = 18'h00400;  4'h8: r = 18'h00001;
        4'h9: r = 18'h00002;  4'hA: r = 18'h00004;
        4'hB: r = 18'h0000A;  4'hC: r = 18'h00010;
        4'hD: r = 18'h00064;  4'hE: r = 18'h001F4;
        4'hF: r = 18'h003E8;  default: r = 18'h00000;
      endcase
    end else begin
      unique case (div)
        4'h1: r = 18'h00400;  4'h2: r = 18'h00800;
        4'h3: r = 18'h01000;  4'h4: r = 18'h02000;
        4'h5: r = 18'h04000;  4'h6: r = 18'h08000;
        4'h7: r = 18'h10000;  4'h8: r = 18'h003E8;
        4'h9: r = 18'h007D0;  4'hA: r = 18'h01388;
        4'hB: r = 18'h02710;  4'hC: r = 18'h04E20;
        4'hD: r = 18'h0C350;  4'hE: r = 18'h186A0;
        4'hF: r = 18'h30D40;  default: r = 18'h00000;
      endcase
    end
    return r;
  endfunction

endpackage

//--- hw/ptc_src_edge.sv
// periodic tick counter: source clock synchroniser and edge finder
// assumes the source toggles slower than a quarter of clk_in
`timescale 1ns/1ps
`default_nettype none

module ptc_src_edge (
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic src_in,
  output logic      rise_out
);

  // ---------------------------------------------------------------
  // two-stage synchroniser, then a history stage for the edge
  // ---------------------------------------------------------------
  logic meta_reg;
  logic sync_reg;
  logic hist_reg;

  // only sync_reg reads meta_reg, to keep metastability contained
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      hist_reg <= 1'b0;
      rise_out <= 1'b0;
    end else begin
      meta_reg <= src_in;
      sync_reg <= meta_reg;
      hist_reg <= sync_reg;
      rise_out <= sync_reg & ~hist_reg;
    end
  end

endmodule
`default_nettype wire

//--- hw/ptc_prescaler.sv
// periodic tick counter: prescaler counting synchronised edges
// assumes edge_in is a one-cycle pulse in the clk_in domain
`timescale 1ns/1ps
`default_nettype none

module ptc_prescaler (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        clear_in,
  input  wire logic        run_in,
  input  wire logic        edge_in,
  input  wire logic [17:0] ratio_in,
  output logic             tick_out
);

  logic [17:0] cnt_reg;

  // ---------------------------------------------------------------
  // divide: a tick each ratio_in edges; hold while not running
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || clear_in) begin
      cnt_reg  <= 18'h00000;
      tick_out <= 1'b0;
    end else if (run_in && edge_in) begin
      if (cnt_reg == ratio_in - 18'h00001) begin
        cnt_reg  <= 18'h00000;
        tick_out <= 1'b1;
      end else begin
        cnt_reg  <= cnt_reg + 18'h00001;
        tick_out <= 1'b0;
      end
    end else begin
      tick_out <= 1'b0; // frozen count is kept
    end
  end

endmodule
`default_nettype wire

//--- tb/ptc_top_chk.sv
// periodic tick counter: port-level checker for the AXI4-Lite side
// assumes it is bound to ptc_top with a single clk_in domain
`timescale 1ns/1ps
`default_nettype none

module ptc_top_chk (
  input wire logic        clk_in,
  input wire logic        rst_n_in,
  input wire logic        s_axi_awvalid_in,
  input wire logic        s_axi_awready_out,
  input wire logic        s_axi_wvalid_in,
  input wire logic        s_axi_wready_out,
  input wire logic        s_axi_bvalid_out,
  input wire logic        s_axi_bready_in,
  input wire logic        s_axi_arvalid_in,
  input wire logic        s_axi_arready_out,
  input wire logic [7:0]  s_axi_araddr_in,
  input wire logic        s_axi_rvalid_out,
  input wire logic        s_axi_rready_in,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic [1:0]  s_axi_rresp_out,
  input wire logic        irq_out
);
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  // both halves of a write taken on one edge
  sequence wr_take;
    s_axi_awvalid_in && s_axi_awready_out &&
    s_axi_wvalid_in && s_axi_wready_out;
  endsequence

  wr_answer_a: assert property (wr_take |-> ##[1:2] s_axi_bvalid_out)
    else $error("write response late");
  wr_hold_a: assert property (s_axi_bvalid_out && !s_axi_bready_in
    |=> s_axi_bvalid_out) else $error("bvalid dropped early");
  rd_answer_a: assert property (s_axi_arvalid_in && s_axi_arready_out
    |=> s_axi_rvalid_out) else $error("read data late");
  rd_hold_a: assert property (s_axi_rvalid_out && !s_axi_rready_in
    |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
    else $error("read data not held");
  ar_block_a: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
    else $error("read taken while answer pending");
  rd_err_a: assert property (s_axi_arvalid_in && s_axi_arready_out &&
    s_axi_araddr_in > 8'h10 |=> s_axi_rresp_out == ptc_pkg::RESP_SLVERR)
    else $error("unmapped read not refused");
  upper_zero_a: assert property (s_axi_rvalid_out |->
    s_axi_rdata_out[31:8] == 24'h000000) else $error("upper bits set");
  reset_quiet_a: assert property ($rose(rst_n_in) |-> !irq_out &&
    !s_axi_bvalid_out && !s_axi_rvalid_out) else $error("busy after reset");
endmodule

bind ptc_top ptc_top_chk u_chk (.*);

`default_nettype wire

//--- tb/ptc_top_tb.sv
// periodic tick counter: register-level self-checking testbench
// assumes ptc_top alone, sources made here as slow pulse trains
`timescale 1ns/1ps
`default_nettype none

module ptc_top_tb;
  logic        clk_in  = 1'b0;
  logic        rst_n   = 1'b0;
  logic [2:0]  src     = 3'h0;
  logic        debug   = 1'b0;
  logic        awvalid = 1'b0;
  logic        wvalid  = 1'b0;
  logic        bready  = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready  = 1'b0;
  logic [7:0]  awaddr  = 8'h00;
  logic [7:0]  araddr  = 8'h00;
  logic [31:0] wdata   = 32'h00000000;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]  bresp, rresp, resp;
  logic [31:0] rdata;
  int          n_fail   = 0;
  int          compares = 0;

  // ---------------------------------------------------------------
  // clock and design
  // ---------------------------------------------------------------
  initial forever #12.5 clk_in = ~clk_in;

  ptc_top dut (.clk_in(clk_in), .rst_n_in(rst_n),
    .low_power_osc_clock_in(src[0]), .external_ref_clock_in(src[1]),
    .internal_ref_clock_in(src[2]), .debug_halt_in(debug),
    .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_awaddr_in(awaddr), .s_axi_awprot_in(3'h0),
    .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_bresp_out(bresp), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_araddr_in(araddr),
    .s_axi_arprot_in(3'h0), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .irq_out(irq));

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic end_sim;
    $display("checks %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // ready is looked at mid-cycle, so it is settled for the next edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic a_ok, w_ok, got;
    got = 1'b0;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    awaddr  <= a;
    wdata   <= d;
    for (int i = 0; i < 50 && !got; i++) begin
      @(negedge clk_in);
      a_ok = awvalid && awready;
      w_ok = wvalid && wready;
      got  = bvalid && bready;
      resp = bresp;
      @(posedge clk_in);
      if (a_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
      if (got) bready <= 1'b0;
    end
    if (!got) begin
      n_fail++;
      end_sim();
    end
    // idle edge, so a next call never re-drives in this time step
    @(posedge clk_in);
  endtask

  // rready is offered with the address and held until the answer
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic a_ok, got;
    got = 1'b0;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    araddr  <= a;
    for (int i = 0; i < 50 && !got; i++) begin
      @(negedge clk_in);
      a_ok = arvalid && arready;
      got  = rvalid && rready;
      d    = rdata;
      resp = rresp;
      @(posedge clk_in);
      if (a_ok) arvalid <= 1'b0;
      if (got) rready <= 1'b0;
    end
    if (!got) begin
      n_fail++;
      end_sim();
    end
    // idle edge, so a next call never re-drives in this time step
    @(posedge clk_in);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e,
                    input string nm);
    logic [31:0] d;
    rd(a, d);
    chk(nm, e, d);
  endtask

  task automatic ci(input logic e);
    @(negedge clk_in);
    chk("irq", {31'h0, e}, {31'h0, irq});
    @(posedge clk_in);
  endtask

  // n rising edges on source s, each level held three cycles
  task automatic pl(input int s, input int n);
    repeat (n) begin
      src[s] <= 1'b1;
      repeat (3) @(posedge clk_in);
      src[s] <= 1'b0;
      repeat (3) @(posedge clk_in);
    end
    repeat (4) @(posedge clk_in);
  endtask

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk_in);
    rst_n <= 1'b1;
    @(posedge clk_in);
    rc(ptc_pkg::OFS_CTRL, 0, "control");
    rc(ptc_pkg::OFS_COMPARE, 0, "compare");
    pl(0, 3);
    rc(ptc_pkg::OFS_COUNT, 0, "count");
    $display("test reset done");
    wr(ptc_pkg::OFS_CTRL, 32'h18);
    wr(ptc_pkg::OFS_COMPARE, 32'h3);
    rc(ptc_pkg::OFS_COMPARE, 3, "compare");
    pl(0, 3);
    rc(ptc_pkg::OFS_COUNT, 3, "count");
    rc(ptc_pkg::OFS_STATUS, 0, "status");
    pl(0, 1);
    rc(ptc_pkg::OFS_COUNT, 0, "count");
    rc(ptc_pkg::OFS_STATUS, 1, "status");
    ci(1'b1);
    wr(ptc_pkg::OFS_COUNT, 32'h55);
    rc(ptc_pkg::OFS_COUNT, 0, "count");
    wr(ptc_pkg::OFS_STATUS, 32'h1);
    rc(ptc_pkg::OFS_STATUS, 0, "status");
    ci(1'b0);
    $display("test wrap done");
    wr(ptc_pkg::OFS_MASK, 32'h0);
    wr(ptc_pkg::OFS_COMPARE, 32'h0);
    pl(0, 1);
    rc(ptc_pkg::OFS_STATUS, 1, "status");
    ci(1'b0);
    wr(ptc_pkg::OFS_MASK, 32'h1);
    ci(1'b1);
    wr(ptc_pkg::OFS_STATUS, 32'h1);
    pl(0, 1);
    rc(ptc_pkg::OFS_CTRL, 32'h98, "control");
    wr(ptc_pkg::OFS_CTRL, 32'h98);
    rc(ptc_pkg::OFS_STATUS, 0, "status");
    ci(1'b0);
    $display("test zero compare done");
    wr(ptc_pkg::OFS_CTRL, 32'h19);
    wr(ptc_pkg::OFS_COMPARE, 32'h5);
    pl(0, 3);
    rc(ptc_pkg::OFS_COUNT, 1, "count");
    wr(ptc_pkg::OFS_COMPARE, 32'h5);
    rc(ptc_pkg::OFS_COUNT, 0, "count");
    pl(0, 1);
    rc(ptc_pkg::OFS_COUNT, 0, "count");
    pl(0, 2);
    wr(ptc_pkg::OFS_CTRL, 32'h19);
    rc(ptc_pkg::OFS_COUNT, 1, "count");
    wr(ptc_pkg::OFS_CTRL, 32'h1A);
    rc(ptc_pkg::OFS_COUNT, 0, "count");
    wr(ptc_pkg::OFS_CTRL, 32'h11);
    pl(0, 7);
    rc(ptc_pkg::OFS_COUNT, 0, "count");
    pl(0, 1);
    rc(ptc_pkg::OFS_COUNT, 1, "count");
    $display("test clears done");
    wr(ptc_pkg::OFS_CTRL, 32'h38);
    pl(0, 2);
    rc(ptc_pkg::OFS_COUNT, 0, "count");
    pl(1, 1000);
    rc(ptc_pkg::OFS_COUNT, 1, "count");
    wr(ptc_pkg::OFS_CTRL, 32'h58);
    rc(ptc_pkg::OFS_COUNT, 0, "count");
    pl(2, 1);
    rc(ptc_pkg::OFS_COUNT, 1, "count");
    debug <= 1'b1;
    pl(2, 2);
    rc(ptc_pkg::OFS_COUNT, 1, "count");
    debug <= 1'b0;
    pl(2, 1);
    rc(ptc_pkg::OFS_COUNT, 2, "count");
    wr(ptc_pkg::OFS_CTRL, 32'h78);
    rc(ptc_pkg::OFS_COUNT, 0, "count");
    wr(ptc_pkg::OFS_CTRL, 32'h50);
    pl(2, 2);
    rc(ptc_pkg::OFS_COUNT, 0, "count");
    $display("test sources done");
    wr(8'h14, 32'h1);
    chk("bresp", {30'h0, ptc_pkg::RESP_SLVERR}, {30'h0, resp});
    rc(8'h14, 0, "unmapped");
    chk("rresp", {30'h0, ptc_pkg::RESP_SLVERR}, {30'h0, resp});
    $display("test unmapped done");
    end_sim();
  end
endmodule

`default_nettype wire
